// *** rtl/dph_host_port.sv ***
`timescale 1ns/10ps
`default_nettype none
module dph_host_port
    import dph_pkg::*;
(
    // Clock and reset
    input  wire logic              CLK_SYS_I,
    input  wire logic              ARST_N_I,
    // Host bus pins
    input  wire logic              HOST_STYLE_SELECT_I,
    input  wire logic              CHIP_SELECT_LOW_ACTIVE_N_I,
    input  wire logic              CHIP_SELECT_HIGH_ACTIVE_I,
    input  wire logic              RD_E_I,
    input  wire logic              WR_RW_I,
    input  wire logic              CMD_DATA_SEL_I,
    input  wire logic [DATA_W-1:0] DATA_I,
    output logic      [DATA_W-1:0] DATA_O,
    output logic                   DATA_OE_O,
    // Write side towards the driver core
    output logic                   WR_STB_O,
    output logic      [DATA_W-1:0] WR_DATA_O,
    output logic                   WR_IS_DATA_O,
    // Read side towards the driver core
    output logic                   RD_REQ_O,
    output logic                   RD_IS_DATA_O,
    input  wire logic [DATA_W-1:0] RD_DATA_I,
    // Status
    output logic                   STYLE_68_O,
    output logic                   READY_O
);
    typedef struct packed {
        logic              style;
        logic              locked;
        logic [LOCK_W-1:0] cnt;
        logic              wr_prev;
        logic              rd_prev;
        logic              wr_stb;
        logic [DATA_W-1:0] wr_data;
        logic              wr_is_data;
        logic              rd_req;
        logic              rd_is_data;
        logic [DATA_W-1:0] dout;
        logic              oe;
    } dph_core_t;

    dph_core_t         st;
    dph_core_t         next_st;
    dph_pin_if         pins ();

    logic              sel;
    logic              rd_e;
    logic              wr_rw;
    logic              cmdd;
    logic [DATA_W-1:0] din;
    logic              rd_act;
    logic              wr_act;

    assign pins.raw = {HOST_STYLE_SELECT_I,
                       CHIP_SELECT_HIGH_ACTIVE_I,
                       CHIP_SELECT_LOW_ACTIVE_N_I,
                       WR_RW_I,
                       RD_E_I,
                       CMD_DATA_SEL_I,
                       DATA_I};

    dph_sync u_sync (
        .clk_i     (CLK_SYS_I),
        .arst_n_i  (ARST_N_I),
        .pins      (pins)
    );

    assign rd_e  = pins.filt[BIT_RD_E];
    assign wr_rw = pins.filt[BIT_WR_RW];
    assign cmdd  = pins.filt[BIT_CMDD];
    assign din   = pins.filt[BIT_DATA +: DATA_W];
    // Both chip selects must agree before anything is seen
    assign sel   = ~pins.filt[BIT_CS_LN] & pins.filt[BIT_CS_H];

    // Strobe decode per host style
    always_comb begin
        rd_act = 1'b0;
        wr_act = 1'b0;
        if (st.locked && sel) begin
            if (st.style == STYLE_68) begin
                rd_act = rd_e & wr_rw;
                wr_act = rd_e & ~wr_rw;
            end else begin
                rd_act = ~rd_e;
                wr_act = ~wr_rw;
            end
        end
    end

    always_comb begin
        next_st         = st;
        next_st.wr_stb  = 1'b0;
        next_st.rd_req  = 1'b0;
        next_st.wr_prev = wr_act;
        next_st.rd_prev = rd_act;
        // Style pin is taken once after the synchroniser has settled
        if (!st.locked) begin
            next_st.cnt = st.cnt + LOCK_W'(1);
            if (st.cnt == LOCK_CNT) begin
                next_st.locked = 1'b1;
                next_st.style  = pins.filt[BIT_STYLE];
            end
        end
        // Capture on the leading edge of the write phase
        if (wr_act && !st.wr_prev) begin
            next_st.wr_stb     = 1'b1;
            next_st.wr_data    = din;
            next_st.wr_is_data = cmdd;
        end
        if (rd_act && !st.rd_prev) begin
            next_st.rd_req     = 1'b1;
            next_st.rd_is_data = cmdd;
        end
        // Bus is driven for the whole read phase
        next_st.oe = rd_act;
        if (rd_act) begin
            next_st.dout = RD_DATA_I;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign DATA_O       = st.dout;
    assign DATA_OE_O    = st.oe;
    assign WR_STB_O     = st.wr_stb;
    assign WR_DATA_O    = st.wr_data;
    assign WR_IS_DATA_O = st.wr_is_data;
    assign RD_REQ_O     = st.rd_req;
    assign RD_IS_DATA_O = st.rd_is_data;
    assign STYLE_68_O   = st.style;
    assign READY_O      = st.locked;

    AST_OE_80: assert property (
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        (st.locked && st.style != STYLE_68 && sel && !rd_e)
        |=> DATA_OE_O)
        else $error("read low did not drive the bus");

    AST_WR_80: assert property (
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        (st.locked && st.style != STYLE_68 && sel && !wr_rw && !st.wr_prev)
        |=> (WR_STB_O && WR_DATA_O == $past(din)))
        else $error("write fall did not capture data");

    AST_STB_ONE: assert property (
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        WR_STB_O && $past(wr_act) |=> !WR_STB_O || !$past(wr_act, 2))
        else $error("write strobe repeated in one phase");

    AST_E_68: assert property (
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        (st.locked && st.style == STYLE_68 && sel && !wr_rw && $rose(rd_e))
        |=> WR_STB_O)
        else $error("enable rise did not capture a write");

    AST_RW_68: assert property (
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        (st.locked && st.style == STYLE_68)
        |=> DATA_OE_O == $past(sel && rd_e && wr_rw))
        else $error("direction line did not set bus drive");

    AST_SEL: assert property (
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        !sel |=> (!DATA_OE_O && !WR_STB_O && !RD_REQ_O))
        else $error("activity while not selected");

    AST_STYLE: assert property (
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        st.locked |=> (st.locked && $stable(st.style)))
        else $error("host style changed after lock");

    AST_RDREQ_80: assert property (
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        (st.locked && st.style != STYLE_68 && sel && !rd_e && !st.rd_prev)
        |=> (RD_REQ_O && RD_IS_DATA_O == $past(cmdd)))
        else $error("read fall did not raise a read request");

    AST_WR_68: assert property (
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        (st.locked && st.style == STYLE_68 && sel && rd_e && !wr_rw
         && !st.wr_prev)
        |=> (WR_STB_O && WR_DATA_O == $past(din)
             && WR_IS_DATA_O == $past(cmdd)))
        else $error("enable phase did not capture write data");

    AST_RD_68: assert property (
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        (st.locked && st.style == STYLE_68 && sel && rd_e && wr_rw
         && !st.rd_prev)
        |=> (RD_REQ_O && !WR_STB_O))
        else $error("read direction did not raise a read request");

    AST_DOUT: assert property (
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        DATA_OE_O |-> DATA_O == $past(RD_DATA_I))
        else $error("driven bus does not carry the core byte");

    AST_RD_ONE: assert property (
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        RD_REQ_O |=> !RD_REQ_O)
        else $error("read request repeated in one phase");

    AST_QUIET: assert property (
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        !st.locked |=> (!WR_STB_O && !RD_REQ_O && !DATA_OE_O))
        else $error("activity before host style was latched");
endmodule : dph_host_port
`default_nettype wire

// *** rtl/dph_pkg.sv ***
`default_nettype none
package dph_pkg;
    // Packed pin vector layout, shared by the synchroniser and the core
    localparam int unsigned PIN_W     = 14;
    localparam int unsigned DATA_W    = 8;
    localparam int unsigned BIT_DATA  = 0;
    localparam int unsigned BIT_CMDD  = 8;
    localparam int unsigned BIT_RD_E  = 9;
    localparam int unsigned BIT_WR_RW = 10;
    localparam int unsigned BIT_CS_LN = 11;
    localparam int unsigned BIT_CS_H  = 12;
    localparam int unsigned BIT_STYLE = 13;

    // Idle pin levels: strobes high, low-active select deasserted
    localparam logic [PIN_W-1:0] PIN_RST = 14'h0E00;

    // Host style encoding on the select pin
    localparam logic STYLE_68 = 1'b1;

    // Cycles after reset before the style pin is taken
    localparam int unsigned  LOCK_W   = 3;
    localparam logic [LOCK_W-1:0] LOCK_CNT = 3'h6;
endpackage : dph_pkg
`default_nettype wire

// *** rtl/dph_pin_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface dph_pin_if
    import dph_pkg::*;
();
    logic [PIN_W-1:0] raw;
    logic [PIN_W-1:0] filt;

    modport sync (input raw, output filt);
    modport core (output raw, input filt);
endinterface : dph_pin_if
`default_nettype wire

// *** rtl/dph_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module dph_sync
    import dph_pkg::*;
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    // Pin vector
    dph_pin_if.sync   pins
);
    typedef struct packed {
        logic [PIN_W-1:0] ff1;
        logic [PIN_W-1:0] ff2;
        logic [PIN_W-1:0] ff3;
        logic [PIN_W-1:0] filt;
    } dph_sync_t;

    dph_sync_t        st;
    dph_sync_t        next_st;
    logic [PIN_W-1:0] next_filt;

    // A change is taken once the second and third stages agree
    genvar g;
    generate
        for (g = 0; g < PIN_W; g++) begin : g_bit
            assign next_filt[g] = (st.ff2[g] == st.ff3[g]) ? st.ff3[g]
                                                           : st.filt[g];
        end
    endgenerate

    always_comb begin
        next_st      = st;
        next_st.ff1  = pins.raw;
        next_st.ff2  = st.ff1;
        next_st.ff3  = st.ff2;
        next_st.filt = next_filt;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st <= {PIN_RST, PIN_RST, PIN_RST, PIN_RST};
        end else begin
            st <= next_st;
        end
    end

    assign pins.filt = st.filt;
endmodule : dph_sync
`default_nettype wire

// *** verif/dph_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module dph_host_model (
    // Clock and mode
    input  wire logic       clk_i,
    input  wire logic       style_68_i,
    // Device side
    input  wire logic       dev_oe_i,
    input  wire logic [7:0] dev_data_i,
    // Host pins
    output logic            cs_low_n_o,
    output logic            cs_high_o,
    output logic            rd_e_o,
    output logic            wr_rw_o,
    output logic            cmd_o,
    output logic      [7:0] data_o
);
    logic       drv  = 1'b0;
    logic [7:0] wd   = 8'h00;
    logic [7:0] last = 8'h00;

    // Released bus shows the inverse of its last level
    assign data_o = drv ? wd : (dev_oe_i ? dev_data_i : ~last);
    always @(posedge clk_i) last <= data_o;
    initial {cs_low_n_o, cs_high_o, rd_e_o, wr_rw_o, cmd_o} = 5'h1E;

    task automatic idle();
        cs_low_n_o <= 1'b1;
        rd_e_o     <= ~style_68_i;
        wr_rw_o    <= 1'b1;
    endtask

    task automatic xfer(input logic rd, input logic [1:0] cs,
                        input logic c, input logic [7:0] d);
        @(posedge clk_i);
        {cs_low_n_o, cs_high_o} <= cs;
        cmd_o <= c;
        wd    <= d;
        drv   <= ~rd;
        if (style_68_i) wr_rw_o <= rd;
        @(posedge clk_i);
        if (style_68_i) rd_e_o <= 1'b1;
        else if (rd) rd_e_o <= 1'b0;
        else wr_rw_o <= 1'b0;
        repeat (5) @(posedge clk_i);
        // Data moves late in the strobe, so only a leading capture passes
        wd <= ~d;
        repeat (3) @(posedge clk_i);
        rd_e_o <= ~style_68_i;
        if (!style_68_i) wr_rw_o <= 1'b1;
        repeat (7) @(posedge clk_i);
        drv        <= 1'b0;
        wr_rw_o    <= 1'b1;
        cs_low_n_o <= 1'b1;
    endtask
endmodule // dph_host_model
`default_nettype wire

// *** verif/test_dual_mode_parallel_host_strobes.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_dual_mode_parallel_host_strobes
    import dph_pkg::*;
;
    logic              clk    = 1'b0;
    logic              arst_n = 1'b0;
    logic              style  = 1'b0;
    logic              mstyle = 1'b0;
    logic [DATA_W-1:0] rd_data = 8'h00;
    logic              cs_ln, cs_h, rd_e, wr_rw, cmd, oe, wstb, wisd;
    logic              rreq, risd, s68, rdy;
    logic [DATA_W-1:0] din, dout, wdat;
    int                err_count = 0;
    int                n_checks  = 0;

    always #50 clk = ~clk;

    dph_host_model i_host (.clk_i(clk), .style_68_i(mstyle), .dev_oe_i(oe),
        .dev_data_i(dout), .cs_low_n_o(cs_ln), .cs_high_o(cs_h),
        .rd_e_o(rd_e), .wr_rw_o(wr_rw), .cmd_o(cmd), .data_o(din));
    dph_host_port i_dut (.CLK_SYS_I(clk), .ARST_N_I(arst_n),
        .HOST_STYLE_SELECT_I(style), .CHIP_SELECT_LOW_ACTIVE_N_I(cs_ln),
        .CHIP_SELECT_HIGH_ACTIVE_I(cs_h), .RD_E_I(rd_e), .WR_RW_I(wr_rw),
        .CMD_DATA_SEL_I(cmd), .DATA_I(din), .DATA_O(dout), .DATA_OE_O(oe),
        .WR_STB_O(wstb), .WR_DATA_O(wdat), .WR_IS_DATA_O(wisd),
        .RD_REQ_O(rreq), .RD_IS_DATA_O(risd), .RD_DATA_I(rd_data),
        .STYLE_68_O(s68), .READY_O(rdy));

    task automatic check(input string w, input logic [7:0] e,
                         input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic finish_test();
        $display("Checks %0d, errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic do_reset(input logic st);
        int n;
        @(posedge clk);
        arst_n <= 1'b0;
        style  <= st;
        mstyle <= st;
        @(posedge clk);
        i_host.idle();
        repeat (11) @(posedge clk);
        arst_n <= 1'b1;
        n = 0;
        while (rdy !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        check("ready", 8'h01, {7'h0, rdy});
        check("style", {7'h0, st}, {7'h0, s68});
    endtask

    // One host transfer, counting what the port reports meanwhile
    task automatic run(input logic rd, input logic [1:0] cs, input logic c,
                       input logic [7:0] d, output int ws, output int rq,
                       output int on, output logic [7:0] cap);
        ws = 0;
        rq = 0;
        on = 0;
        cap = 8'h00;
        fork
            i_host.xfer(rd, cs, c, d);
            repeat (24) begin
                @(negedge clk);
                if (wstb === 1'b1) ws++;
                if (rreq === 1'b1) rq++;
                if (oe === 1'b1) begin
                    on++;
                    cap = dout;
                end
            end
        join
    endtask

    task automatic t_write(input logic [7:0] d, input logic c);
        int ws, rq, on;
        logic [7:0] cap;
        @(posedge clk);
        style <= ~mstyle; // Late change must be ignored
        run(1'b0, 2'b01, c, d, ws, rq, on, cap);
        check("wr pulses", 8'h01, ws[7:0]);
        check("wr data", d, wdat);
        check("wr cmd", {7'h0, c}, {7'h0, wisd});
        check("wr oe", 8'h00, on[7:0]);
        check("style kept", {7'h0, mstyle}, {7'h0, s68});
    endtask

    task automatic t_read(input logic [7:0] d, input logic c);
        int ws, rq, on;
        logic [7:0] cap;
        @(posedge clk);
        rd_data <= d;
        run(1'b1, 2'b01, c, 8'h00, ws, rq, on, cap);
        check("rd pulses", 8'h01, rq[7:0]);
        check("rd oe cycles", 8'h08, on[7:0]);
        check("rd data", d, cap);
        check("rd cmd", {7'h0, c}, {7'h0, risd});
        check("rd no write", 8'h00, ws[7:0]);
        check("oe released", 8'h00, {7'h0, oe});
    endtask

    task automatic t_nosel();
        int ws, rq, on;
        logic [7:0] cap;
        run(1'b0, 2'b11, 1'b0, 8'h3C, ws, rq, on, cap);
        check("nosel wr", 8'h00, ws[7:0]);
        run(1'b1, 2'b00, 1'b0, 8'h00, ws, rq, on, cap);
        check("nosel rd", 8'h00, rq[7:0]);
        check("nosel oe", 8'h00, on[7:0]);
    endtask

    initial begin
        do_reset(1'b0);
        t_write(8'hA5, 1'b1);
        t_read(8'h3C, 1'b0);
        t_nosel();
        t_write(8'h5A, 1'b0);
        do_reset(1'b1);
        t_read(8'hC3, 1'b1);
        t_write(8'h96, 1'b1);
        t_nosel();
        finish_test();
    end

    initial begin
        repeat (1500) @(posedge clk);
        err_count++;
        finish_test();
    end
endmodule // test_dual_mode_parallel_host_strobes
`default_nettype wire
